// ---- cmts_pkg.sv ----
// shared constants and carrier types for the transfer select block
package cmts_pkg;

  // ==========================================================
  // command mask bit positions
  localparam int MASK_WIDTH    = 6;
  localparam int ARB_BIT       = 5;
  localparam int CONTROL_BIT   = 4;
  localparam int CLEAR_BIT     = 3;
  localparam int REQ_FRESH_BIT = 2;
  localparam int LOW_BYTES_BIT = 1;
  localparam int HIGH_BYTES_BIT = 0;

  // ==========================================================
  // field widths and reset values
  localparam int ID_WIDTH      = 29;
  localparam int DLC_WIDTH     = 4;
  localparam int WORD_WIDTH    = 32;
  localparam int OBJ_ADDR_WIDTH = 5;
  localparam logic [MASK_WIDTH-1:0] MASK_RESET = 6'h00;

  typedef struct packed {
    logic                 transmitRequest;
    logic                 irqPending;
    logic                 freshData;
    logic [DLC_WIDTH-1:0] dataLength;
  } cmts_ctrl_type;

  typedef struct packed {
    logic [ID_WIDTH-1:0] id;
    logic                dir;
    logic                xtd;
    logic                objectValid;
  } cmts_arb_type;

  typedef struct packed {
    cmts_arb_type          arb;
    cmts_ctrl_type         ctrl;
    logic [WORD_WIDTH-1:0] lowLo;
    logic [WORD_WIDTH-1:0] lowHi;
    logic [WORD_WIDTH-1:0] highLo;
    logic [WORD_WIDTH-1:0] highHi;
  } cmts_obj_type;

  localparam cmts_obj_type OBJ_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_REQ,
    ST_RD_DATA,
    ST_MERGE,
    ST_WR_REQ
  } cmts_state_type;

endpackage : cmts_pkg

// ---- cmts_transfer_select.sv ----
// message interface transfer select: buffer registers and object access
// Overview of operation
// R1 - read with arb select loads arbitration buffer
// R2 - write with control select stores buffered control
// R3 - read with control select loads control buffer
// R4 - read with clear select clears pending flag
// R5 - clear select has no effect on writes
// R6 - write with bit two sets transmit request
// R7 - set request overrides buffered transmit request bit
// R8 - read with bit two clears fresh data
// R9 - buffered control shows values before clearing
// R10 - write with low select stores bytes 0-7
// R11 - read with low select loads bytes 0-7
// R12 - high select moves bytes 8-15 by direction
// R13 - whole transfer is one object read-modify-write
`timescale 1ns/1ps
module cmts_transfer_select #(
  parameter int ObjAddrWidth = cmts_pkg::OBJ_ADDR_WIDTH
) (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic                           startTransfer,
  input  wire logic                           writeNotRead,
  input  wire logic [cmts_pkg::MASK_WIDTH-1:0] cmdMask,
  input  wire logic [ObjAddrWidth-1:0]        objectNumber,
  input  wire logic                           bufLoad,
  input  wire cmts_pkg::cmts_obj_type         bufLoadData,
  input  wire cmts_pkg::cmts_obj_type         ramRdata,
  output logic                                ramReq,
  output logic                                ramWrite,
  output logic [ObjAddrWidth-1:0]             ramAddr,
  output cmts_pkg::cmts_obj_type              ramWdata,
  output cmts_pkg::cmts_obj_type              bufData,
  output logic                                busy,
  output logic                                done
);

  // ==========================================================
  // parameter check
  initial begin
    if (ObjAddrWidth < 1 || ObjAddrWidth > 16) begin
      $error("object address width out of range");
    end
  end

  function automatic logic maskSel(
    input logic [cmts_pkg::MASK_WIDTH-1:0] m,
    input int                              pos
  );
    maskSel = m[pos];
  endfunction : maskSel

  // ==========================================================
  // state
  cmts_pkg::cmts_state_type          state_reg;
  cmts_pkg::cmts_state_type          state_next;
  logic [cmts_pkg::MASK_WIDTH-1:0]   mask_reg;
  logic                              wr_reg;
  cmts_pkg::cmts_obj_type            obj_reg;
  cmts_pkg::cmts_obj_type            buf_reg;
  cmts_pkg::cmts_obj_type            buf_next;
  cmts_pkg::cmts_obj_type            merged;
  cmts_pkg::cmts_ctrl_type           ctrlWr;
  cmts_pkg::cmts_ctrl_type           ctrlRd;
  logic                              ramReq_reg;
  logic                              ramWrite_reg;
  logic [ObjAddrWidth-1:0]           ramAddr_reg;
  cmts_pkg::cmts_obj_type            ramWdata_reg;
  logic                              busy_reg;
  logic                              done_reg;

  // ==========================================================
  // decoded selects
  wire logic selArb   = maskSel(mask_reg, cmts_pkg::ARB_BIT);
  wire logic selCtrl  = maskSel(mask_reg, cmts_pkg::CONTROL_BIT);
  wire logic selClr   = maskSel(mask_reg, cmts_pkg::CLEAR_BIT);
  wire logic selReq   = maskSel(mask_reg, cmts_pkg::REQ_FRESH_BIT);
  wire logic selLow   = maskSel(mask_reg, cmts_pkg::LOW_BYTES_BIT);
  wire logic selHigh  = maskSel(mask_reg, cmts_pkg::HIGH_BYTES_BIT);
  wire logic inIdle   = (state_reg == cmts_pkg::ST_IDLE);
  wire logic inMerge  = (state_reg == cmts_pkg::ST_MERGE);
  wire logic accept   = inIdle && startTransfer;
  // software may not reload buffers while an object access is in flight
  wire logic loadOk   = inIdle && bufLoad && !startTransfer;
  wire logic rdXfer   = inMerge && !wr_reg;
  wire logic wrXfer   = inMerge && wr_reg;

  // ==========================================================
  // control merge
  always_comb begin
    ctrlWr = obj_reg.ctrl;
    if (selCtrl) begin
      ctrlWr = buf_reg.ctrl; // [R2]
    end
    if (selReq) begin
      ctrlWr.transmitRequest = 1'b1; // [R6] [R7]
    end
    // clear select deliberately not consulted here [R5]
  end

  always_comb begin
    ctrlRd = obj_reg.ctrl;
    if (selClr) begin
      ctrlRd.irqPending = 1'b0; // [R4]
    end
    if (selReq) begin
      ctrlRd.freshData = 1'b0; // [R8]
    end
  end

  // ==========================================================
  // object image written back
  always_comb begin
    merged = obj_reg;
    if (wr_reg) begin
      merged.ctrl = ctrlWr;
      if (selArb) begin
        merged.arb = buf_reg.arb;
      end
      if (selLow) begin
        merged.lowLo = buf_reg.lowLo; // [R10]
        merged.lowHi = buf_reg.lowHi; // [R10]
      end
      if (selHigh) begin
        merged.highLo = buf_reg.highLo; // [R12]
        merged.highHi = buf_reg.highHi; // [R12]
      end
    end else begin
      merged.ctrl = ctrlRd;
    end
  end

  // ==========================================================
  // buffer next value
  always_comb begin
    buf_next = buf_reg;
    if (loadOk) begin
      buf_next = bufLoadData;
    end else if (rdXfer) begin
      if (selArb) begin
        buf_next.arb = obj_reg.arb; // [R1]
      end
      if (selCtrl) begin
        // pre-clear image, not the cleared one [R3] [R9]
        buf_next.ctrl = obj_reg.ctrl;
      end
      if (selLow) begin
        buf_next.lowLo = obj_reg.lowLo; // [R11]
        buf_next.lowHi = obj_reg.lowHi; // [R11]
      end
      if (selHigh) begin
        buf_next.highLo = obj_reg.highLo; // [R12]
        buf_next.highHi = obj_reg.highHi; // [R12]
      end
    end
  end

  // ==========================================================
  // sequencer: read, capture, merge, write back [R13]
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cmts_pkg::ST_IDLE: begin
        if (startTransfer) begin
          state_next = cmts_pkg::ST_RD_REQ;
        end
      end
      cmts_pkg::ST_RD_REQ:  state_next = cmts_pkg::ST_RD_DATA;
      cmts_pkg::ST_RD_DATA: state_next = cmts_pkg::ST_MERGE;
      cmts_pkg::ST_MERGE:   state_next = cmts_pkg::ST_WR_REQ;
      cmts_pkg::ST_WR_REQ:  state_next = cmts_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= cmts_pkg::ST_IDLE;
      mask_reg  <= cmts_pkg::MASK_RESET;
      wr_reg    <= 1'b0;
      buf_reg   <= cmts_pkg::OBJ_RESET;
    end else begin
      state_reg <= state_next;
      buf_reg   <= buf_next;
      if (accept) begin
        mask_reg <= cmdMask;
        wr_reg   <= writeNotRead;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      obj_reg <= cmts_pkg::OBJ_RESET;
    end else if (state_reg == cmts_pkg::ST_RD_DATA) begin
      obj_reg <= ramRdata;
    end
  end

  // ==========================================================
  // message ram port, all registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ramReq_reg   <= 1'b0;
      ramWrite_reg <= 1'b0;
      ramAddr_reg  <= '0;
      ramWdata_reg <= cmts_pkg::OBJ_RESET;
      busy_reg     <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      ramReq_reg   <= accept || inMerge; // [R13]
      ramWrite_reg <= inMerge;
      done_reg     <= (state_reg == cmts_pkg::ST_WR_REQ);
      busy_reg     <= (state_next != cmts_pkg::ST_IDLE);
      if (accept) begin
        ramAddr_reg <= objectNumber;
      end
      if (inMerge) begin
        ramWdata_reg <= merged;
      end
    end
  end

  assign ramReq   = ramReq_reg;
  assign ramWrite = ramWrite_reg;
  assign ramAddr  = ramAddr_reg;
  assign ramWdata = ramWdata_reg;
  assign bufData  = buf_reg;
  assign busy     = busy_reg;
  assign done     = done_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence readPhase;
    ramReq && !ramWrite ##1 !ramReq ##1 !ramReq;
  endsequence

  sequence writePhase;
    ramReq && ramWrite ##1 done && !ramReq;
  endsequence

  chk_one_access: assert property ( // [R13]
    accept |=> readPhase ##1 writePhase)
    else $error("transfer is not one read then one write");

  chk_read_arb: assert property ( // [R1]
    rdXfer && selArb |=> bufData.arb == $past(obj_reg.arb))
    else $error("arbitration not loaded on read");

  chk_read_arb_keep: assert property ( // [R1]
    rdXfer && !selArb |=> $stable(bufData.arb))
    else $error("arbitration buffer changed without select");

  chk_write_ctrl: assert property ( // [R2]
    wrXfer && selCtrl && !selReq
    |=> ramWdata.ctrl == $past(buf_reg.ctrl))
    else $error("buffered control not stored on write");

  chk_write_keep: assert property ( // [R2]
    wrXfer && !selCtrl && !selReq
    |=> ramWdata.ctrl == $past(obj_reg.ctrl))
    else $error("object control changed without select");

  chk_clear_pend: assert property ( // [R4]
    rdXfer && selClr |=> !ramWdata.ctrl.irqPending)
    else $error("pending flag not cleared");

  chk_clear_ignored: assert property ( // [R5]
    wrXfer && selClr && !selCtrl
    |=> ramWdata.ctrl.irqPending == $past(obj_reg.ctrl.irqPending))
    else $error("clear select acted on a write");

  chk_tx_set: assert property ( // [R6] [R7]
    wrXfer && selReq |=> ramWdata.ctrl.transmitRequest)
    else $error("transmit request not set");

  chk_fresh_clear: assert property ( // [R8]
    rdXfer && selReq |=> !ramWdata.ctrl.freshData)
    else $error("fresh data flag not cleared");

  chk_pre_clear: assert property ( // [R3] [R9]
    rdXfer && selCtrl |=> bufData.ctrl == $past(obj_reg.ctrl))
    else $error("control buffer not pre-clear image");

  chk_low_write: assert property ( // [R10]
    wrXfer && selLow |=> ramWdata.lowLo == $past(buf_reg.lowLo)
                         && ramWdata.lowHi == $past(buf_reg.lowHi))
    else $error("low bytes not stored");

  chk_low_read: assert property ( // [R11]
    rdXfer && selLow |=> bufData.lowLo == $past(obj_reg.lowLo)
                         && bufData.lowHi == $past(obj_reg.lowHi))
    else $error("low bytes not loaded");

  chk_high_move: assert property ( // [R12]
    inMerge && selHigh |=> (wr_reg
      ? ramWdata.highHi == $past(buf_reg.highHi)
      : bufData.highHi == $past(obj_reg.highHi)))
    else $error("high bytes not moved");

endmodule : cmts_transfer_select

// ---- testbench.sv ----
// self-checking bench for the transfer select block
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // stimulus and observed signals
  localparam cmts_pkg::cmts_obj_type OA = {29'h0ABCDEF, 3'h7, 7'h38,
    32'h11111111, 32'h22222222, 32'h33333333, 32'h44444444};
  localparam cmts_pkg::cmts_obj_type OB = {29'h1234567, 3'h2, 7'h05,
    32'hAAAA5555, 32'h5555AAAA, 32'hC3C3C3C3, 32'h3C3C3C3C};
  logic                                clock         = 1'b0;
  logic                                rst           = 1'b1;
  logic                                startTransfer = 1'b0;
  logic                                writeNotRead  = 1'b0;
  logic                                bufLoad       = 1'b0;
  logic [cmts_pkg::MASK_WIDTH-1:0]     cmdMask       = 6'h00;
  logic [cmts_pkg::OBJ_ADDR_WIDTH-1:0] objectNumber  = 5'h00;
  cmts_pkg::cmts_obj_type              bufLoadData   = '0;
  cmts_pkg::cmts_obj_type              ramRdata      = '0;
  cmts_pkg::cmts_obj_type              image         = '0;
  cmts_pkg::cmts_obj_type              ramWdata;
  cmts_pkg::cmts_obj_type              bufData;
  logic [cmts_pkg::OBJ_ADDR_WIDTH-1:0] ramAddr;
  logic                                ramReq;
  logic                                ramWrite;
  logic                                busy;
  logic                                done;
  int                                  n_errors = 0;
  int                                  n_checks = 0;
  int                                  cycles   = 0;
  cmts_transfer_select i_cmts_transfer_select (
    .clock(clock), .rst(rst), .startTransfer(startTransfer),
    .writeNotRead(writeNotRead), .cmdMask(cmdMask),
    .objectNumber(objectNumber), .bufLoad(bufLoad),
    .bufLoadData(bufLoadData), .ramRdata(ramRdata), .ramReq(ramReq),
    .ramWrite(ramWrite), .ramAddr(ramAddr), .ramWdata(ramWdata),
    .bufData(bufData), .busy(busy), .done(done));
  always #20 clock = ~clock;
  // ==========================================================
  // message store: data is only valid one cycle after a read request
  always @(posedge clock) begin
    ramRdata <= (ramReq === 1'b1 && ramWrite === 1'b0) ? image : ~ramRdata;
    if (ramReq === 1'b1 && ramWrite === 1'b1) image <= ramWdata;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      conclude();
    end
  end
  // ==========================================================
  // compares and expectations
  task automatic check_obj(string nm, cmts_pkg::cmts_obj_type e,
                           cmts_pkg::cmts_obj_type g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check_obj
  task automatic check_bit(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  function automatic cmts_pkg::cmts_obj_type exp_wr(
    cmts_pkg::cmts_obj_type b, cmts_pkg::cmts_obj_type o, logic [5:0] m);
    if (m[5]) o.arb = b.arb;
    if (m[4]) o.ctrl = b.ctrl;
    if (m[2]) o.ctrl.transmitRequest = 1'b1;
    if (m[1]) {o.lowLo, o.lowHi} = {b.lowLo, b.lowHi};
    if (m[0]) {o.highLo, o.highHi} = {b.highLo, b.highHi};
    return o;
  endfunction : exp_wr
  function automatic cmts_pkg::cmts_obj_type exp_rd(
    cmts_pkg::cmts_obj_type b, cmts_pkg::cmts_obj_type o, logic [5:0] m);
    // buffer copy is taken from the object before any clearing
    if (m[5]) b.arb = o.arb;
    if (m[4]) b.ctrl = o.ctrl;
    if (m[1]) {b.lowLo, b.lowHi} = {o.lowLo, o.lowHi};
    if (m[0]) {b.highLo, b.highHi} = {o.highLo, o.highHi};
    return b;
  endfunction : exp_rd
  // ==========================================================
  // drivers
  task automatic load(cmts_pkg::cmts_obj_type b);
    @(posedge clock);
    bufLoad     <= 1'b1;
    bufLoadData <= b;
    @(posedge clock);
    bufLoad     <= 1'b0;
  endtask : load
  task automatic wait_done();
    for (int k = 0; k < 10 && done !== 1'b1; k++) @(negedge clock);
    check_bit("done", 1'b1, done);
  endtask : wait_done
  task automatic run(logic wr, logic [5:0] m, logic [4:0] a);
    @(posedge clock);
    startTransfer <= 1'b1;
    writeNotRead  <= wr;
    cmdMask       <= m;
    objectNumber  <= a;
    @(posedge clock);
    startTransfer <= 1'b0;
    wait_done();
    check_bit("ramAddr", 1'b1, ramAddr === a);
  endtask : run
  // ==========================================================
  // scenarios
  task automatic scen_writes();
    cmts_pkg::cmts_obj_type e;
    logic [5:0] ms [9] = '{6'h3F, 6'h20, 6'h10, 6'h08, 6'h04, 6'h14,
                           6'h02, 6'h01, 6'h00};
    foreach (ms[i]) begin
      image = OA;
      load(OB);
      run(1'b1, ms[i], 5'(i));
      e = exp_wr(OB, OA, ms[i]);
      check_obj("write image", e, image);
    end
  endtask : scen_writes
  task automatic scen_reads();
    cmts_pkg::cmts_obj_type o;
    cmts_pkg::cmts_obj_type e;
    logic [5:0] ms [9] = '{6'h3F, 6'h20, 6'h10, 6'h08, 6'h04, 6'h1C,
                           6'h02, 6'h01, 6'h00};
    foreach (ms[i]) begin
      image = OA;
      load(OB);
      run(1'b0, ms[i], 5'(31 - i));
      o = OA;
      if (ms[i][3]) o.ctrl.irqPending = 1'b0;
      if (ms[i][2]) o.ctrl.freshData = 1'b0;
      e = exp_rd(OB, OA, ms[i]);
      check_obj("read buffer", e, bufData);
      check_obj("read image", o, image);
    end
  endtask : scen_reads
  task automatic scen_back_to_back();
    // a load during busy must be dropped; next start rides the done cycle
    image = OA;
    load(OB);
    @(posedge clock);
    startTransfer <= 1'b1;
    writeNotRead  <= 1'b1;
    cmdMask       <= 6'h3F;
    @(posedge clock);
    startTransfer <= 1'b0;
    bufLoad       <= 1'b1;
    bufLoadData   <= ~OB;
    @(posedge clock);
    bufLoad       <= 1'b0;
    repeat (2) @(posedge clock);
    // write-back cycle: the load must not have reached the buffers
    @(negedge clock);
    check_obj("dropped load", OB, bufData);
    check_bit("write pulse", 1'b1, ramReq && ramWrite);
    check_bit("busy", 1'b1, busy);
    @(posedge clock);
    startTransfer <= 1'b1;
    writeNotRead  <= 1'b0;
    @(posedge clock);
    startTransfer <= 1'b0;
    // let the first done pulse pass before waiting for the second
    @(negedge clock);
    check_bit("busy chained", 1'b1, busy);
    wait_done();
    check_obj("chained read", exp_wr(OB, OA, 6'h3F), bufData);
  endtask : scen_back_to_back
  // ==========================================================
  // verdict
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check_obj("reset buffer", '0, bufData);
    check_bit("reset busy", 1'b0, busy);
    check_bit("reset ramReq", 1'b0, ramReq);
    scen_writes();
    scen_reads();
    scen_back_to_back();
    conclude();
  end
endmodule : testbench
